/* File: logic/vcf_param_bank.sv */
// Parameter register bank and command low-pass filter of the voltage target logic.
// Assumes a command-code register port driven by the management bus controller.
// Functional notes
// - Time-constant upper four bits: ignored, read zero.
// - Boot coefficient bits 11:6, used during start-up.
// - Transition coefficient bits 5:0, used otherwise.
// - Minimum-output parameter is a full 16-bit field.
// - Boot duty parameter is a 16-bit field.
// - Transition reciprocal slew is a 16-bit field.
// - Boot reciprocal slew is a 16-bit field.
// - Boot voltage is a 9-bit code.
`timescale 1ns/1ps
module vcf_param_bank #(
  parameter int DATA_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  input wire logic boot_phase,
  input wire logic [DATA_WIDTH-1:0] command_target,
  output logic [DATA_WIDTH-1:0] filtered_target,
  output logic filter_step,
  output logic [15:0] min_output_norm,
  output logic [vcf_pkg::COEFF_WIDTH-1:0] boot_filter_coeff,
  output logic [vcf_pkg::COEFF_WIDTH-1:0] transition_filter_coeff,
  output logic [15:0] boot_duty_norm,
  output logic [15:0] transition_slew_recip_value,
  output logic [15:0] boot_slew_recip_value
);
  // Quiet cycles after the first one between two filter steps, 64 cycles apart.
  localparam int STEP_GAP = 62;

  // All state of the bank: parameters, read answer and step divider.
  typedef struct packed {
    logic [15:0] min_output_norm_param;
    logic [11:0] filter_time_constants;
    logic [15:0] boot_duty_norm_param;
    logic [15:0] transition_slew_recip;
    logic [15:0] boot_slew_recip;
    logic [15:0] rdata;
    logic hit;
    logic [5:0] div_cnt;
    logic step;
  } vcf_bank_state_type;

  vcf_bank_state_type state;
  vcf_bank_state_type next_state;
  logic [vcf_pkg::COEFF_WIDTH-1:0] active_coeff; // Coefficient for the current phase.

  // Register fields drive the consumers straight from flip-flops.
  assign min_output_norm = state.min_output_norm_param;
  assign boot_filter_coeff = state.filter_time_constants[vcf_pkg::BOOT_COEFF_LSB +:
    vcf_pkg::COEFF_WIDTH];
  assign transition_filter_coeff = state.filter_time_constants[vcf_pkg::TRAN_COEFF_LSB +:
    vcf_pkg::COEFF_WIDTH];
  assign boot_duty_norm = state.boot_duty_norm_param;
  assign transition_slew_recip_value = state.transition_slew_recip;
  assign boot_slew_recip_value = state.boot_slew_recip;
  assign reg_rdata = state.rdata;
  assign reg_hit = state.hit;
  assign filter_step = state.step;

  // The boot coefficient applies during start-up, the transition one otherwise.
  assign active_coeff = boot_phase ? boot_filter_coeff : transition_filter_coeff;

  // Register writes, read answers and the 320 ns step divider.
  always_comb begin
    next_state = state;
    // The divider raises one step pulse every 64 cycles.
    if (state.div_cnt == vcf_pkg::STEP_LAST) begin
      next_state.div_cnt = '0;
      next_state.step = 1'b1;
    end else begin
      next_state.div_cnt = state.div_cnt + 6'h01;
      next_state.step = 1'b0;
    end
    // Writes to unknown command codes are dropped without effect.
    if (reg_wr) begin
      case (reg_addr)
        vcf_pkg::ADDR_MIN_OUTPUT: begin
          next_state.min_output_norm_param = reg_wdata;
        end
        vcf_pkg::ADDR_FILTER_TC: begin
          // Only the two coefficient fields are kept; the top bits are lost.
          next_state.filter_time_constants = reg_wdata[11:0];
        end
        vcf_pkg::ADDR_BOOT_DUTY: begin
          // The value is derived from the 9-bit boot voltage code by software.
          next_state.boot_duty_norm_param = reg_wdata;
        end
        vcf_pkg::ADDR_TRAN_SLEW: begin
          next_state.transition_slew_recip = reg_wdata;
        end
        vcf_pkg::ADDR_BOOT_SLEW: begin
          next_state.boot_slew_recip = reg_wdata;
        end
        default: begin
          next_state.hit = state.hit;
        end
      endcase
    end
    // A read returns the old value one cycle later; unknown codes read zero.
    if (reg_rd) begin
      next_state.hit = 1'b1;
      case (reg_addr)
        vcf_pkg::ADDR_MIN_OUTPUT: begin
          next_state.rdata = state.min_output_norm_param;
        end
        vcf_pkg::ADDR_FILTER_TC: begin
          next_state.rdata = {4'h0, state.filter_time_constants};
        end
        vcf_pkg::ADDR_BOOT_DUTY: begin
          next_state.rdata = state.boot_duty_norm_param;
        end
        vcf_pkg::ADDR_TRAN_SLEW: begin
          next_state.rdata = state.transition_slew_recip;
        end
        vcf_pkg::ADDR_BOOT_SLEW: begin
          next_state.rdata = state.boot_slew_recip;
        end
        default: begin
          next_state.rdata = 16'h0000;
          next_state.hit = 1'b0;
        end
      endcase
    end else begin
      next_state.rdata = 16'h0000;
      next_state.hit = 1'b0;
    end
  end

  // State register with documented reset values.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state.min_output_norm_param <= vcf_pkg::RST_MIN_OUTPUT;
      state.filter_time_constants <= vcf_pkg::RST_FILTER_TC;
      state.boot_duty_norm_param <= vcf_pkg::RST_BOOT_DUTY;
      state.transition_slew_recip <= vcf_pkg::RST_TRAN_SLEW;
      state.boot_slew_recip <= vcf_pkg::RST_BOOT_SLEW;
      state.rdata <= 16'h0000;
      state.hit <= 1'b0;
      state.div_cnt <= 6'h00;
      state.step <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // The command filter, stepped by the divider with the phase coefficient.
  vcf_lowpass #(
    .DATA_WIDTH(DATA_WIDTH)
  ) u_lowpass (
    .clk(clk),
    .reset(reset),
    .step(state.step),
    .coeff(active_coeff),
    .target(command_target),
    .value(filtered_target)
  );

  // A write to a code, then a read of the same code.
  sequence write_then_read(logic [7:0] code);
    reg_wr && reg_addr == code && !reg_rd ##1 reg_rd && reg_addr == code && !reg_wr;
  endsequence

  // Reading the time-constant register never shows the top four bits.
  chk_rsvd_reads_zero: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == vcf_pkg::ADDR_FILTER_TC |=> reg_hit && reg_rdata[15:12] == 4'h0)
    else $error("Reserved time-constant bits read nonzero.");

  // A write sets the boot coefficient from bits 11:6 of the data.
  chk_boot_coeff_field: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == vcf_pkg::ADDR_FILTER_TC |=>
    boot_filter_coeff == $past(reg_wdata[11:6]) && (boot_phase ->
    active_coeff == boot_filter_coeff))
    else $error("Boot coefficient not taken from bits 11:6.");

  // A write sets the transition coefficient from bits 5:0 of the data.
  chk_tran_coeff_field: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == vcf_pkg::ADDR_FILTER_TC |=>
    transition_filter_coeff == $past(reg_wdata[5:0]) && (!boot_phase ->
    active_coeff == transition_filter_coeff))
    else $error("Transition coefficient not taken from bits 5:0.");

  // All sixteen bits of the minimum-output parameter read back.
  chk_min_out_back: assert property (@(posedge clk) disable iff (reset)
    write_then_read(vcf_pkg::ADDR_MIN_OUTPUT) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Minimum-output parameter readback mismatch.");

  // All sixteen bits of the boot duty parameter read back.
  chk_boot_duty_back: assert property (@(posedge clk) disable iff (reset)
    write_then_read(vcf_pkg::ADDR_BOOT_DUTY) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Boot duty parameter readback mismatch.");

  // The transition reciprocal slew reaches its output after a write.
  chk_tran_slew_out: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == vcf_pkg::ADDR_TRAN_SLEW |=>
    transition_slew_recip_value == $past(reg_wdata))
    else $error("Transition reciprocal slew not stored.");

  // The boot reciprocal slew reads back in full.
  chk_boot_slew_back: assert property (@(posedge clk) disable iff (reset)
    write_then_read(vcf_pkg::ADDR_BOOT_SLEW) |=> reg_rdata == $past(reg_wdata, 2)
    && boot_slew_recip_value == reg_rdata)
    else $error("Boot reciprocal slew readback mismatch.");

  // Filter steps come exactly every 64 cycles, with no early step between them.
  chk_step_period: assert property (@(posedge clk) disable iff (reset)
    filter_step |=> (!filter_step throughout ##STEP_GAP 1'b1) ##1 filter_step)
    else $error("Filter step spacing is not 64 cycles.");

  // Between steps the filtered target holds still.
  chk_filter_holds: assert property (@(posedge clk) disable iff (reset)
    !filter_step |=> $stable(filtered_target))
    else $error("Filtered target moved without a step.");

  // A step toward a higher, steady target never moves away from it nor past it.
  chk_filter_toward: assert property (@(posedge clk) disable iff (reset)
    filter_step && command_target > filtered_target && $stable(command_target) |=>
    filtered_target >= $past(filtered_target) && filtered_target <= $past(command_target))
    else $error("Filter moved away from its target.");
endmodule

/* File: include/vcf_pkg.sv */
// Package for the voltage command filter parameter bank.
// Assumes a single 200 MHz clock; all users refer to names as vcf_pkg::name.
package vcf_pkg;
  // Command codes of the five parameter registers.
  localparam logic [7:0] ADDR_MIN_OUTPUT = 8'hb4;
  localparam logic [7:0] ADDR_FILTER_TC = 8'hb5;
  localparam logic [7:0] ADDR_BOOT_DUTY = 8'hb6;
  localparam logic [7:0] ADDR_TRAN_SLEW = 8'hb7;
  localparam logic [7:0] ADDR_BOOT_SLEW = 8'hb8;
  // Field positions inside the time-constant register.
  localparam int BOOT_COEFF_LSB = 6;
  localparam int TRAN_COEFF_LSB = 0;
  localparam int COEFF_WIDTH = 6;
  localparam int TC_USED_WIDTH = 12;
  // Values after reset of the parameter registers.
  localparam logic [15:0] RST_MIN_OUTPUT = 16'h0000;
  localparam logic [11:0] RST_FILTER_TC = 12'h000;
  localparam logic [15:0] RST_BOOT_DUTY = 16'h0000;
  localparam logic [15:0] RST_TRAN_SLEW = 16'h0000;
  localparam logic [15:0] RST_BOOT_SLEW = 16'h0000;
  // Scaling of the filter coefficients, as a power of two.
  localparam int COEFF_FRAC_BITS = 11;
  // Width of the boot voltage code that the boot duty is computed from.
  localparam int BOOT_VOLTAGE_WIDTH = 9;
  // Filter update period and the clock period, both in nanoseconds.
  localparam int FILTER_PERIOD_NS = 320;
  localparam int CLK_PERIOD_NS = 5;
  // Clock cycles between two filter updates.
  localparam int STEP_CYCLES = FILTER_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [5:0] STEP_LAST = 6'(STEP_CYCLES - 1);
endpackage

/* File: logic/vcf_lowpass.sv */
// First-order recursive low-pass filter for the voltage command.
// Assumes step is a one-cycle pulse and coeff stays below two to the eleventh.
`timescale 1ns/1ps
module vcf_lowpass #(
  parameter int DATA_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic step,
  input wire logic [vcf_pkg::COEFF_WIDTH-1:0] coeff,
  input wire logic [DATA_WIDTH-1:0] target,
  output logic [DATA_WIDTH-1:0] value
);
  // Accumulator width: data, fraction bits and one sign bit.
  localparam int ACC_WIDTH = DATA_WIDTH + vcf_pkg::COEFF_FRAC_BITS + 1;
  localparam int PROD_WIDTH = DATA_WIDTH + vcf_pkg::COEFF_WIDTH + 2;

  // All state of the filter.
  typedef struct packed {
    logic signed [ACC_WIDTH-1:0] acc;
  } vcf_lowpass_state_type;

  vcf_lowpass_state_type state;
  vcf_lowpass_state_type next_state;
  logic signed [DATA_WIDTH:0] error; // Signed distance from output to target.
  logic signed [PROD_WIDTH-1:0] product; // Coefficient times error.

  // The output is the integer part of the accumulator.
  assign value = state.acc[ACC_WIDTH-2:vcf_pkg::COEFF_FRAC_BITS];

  // Each step adds coeff times the error; the fraction bits divide it down.
  always_comb begin
    next_state = state;
    error = $signed({1'b0, target}) - $signed({1'b0, value});
    product = $signed({1'b0, coeff}) * error;
    if (step) begin
      next_state.acc = state.acc + ACC_WIDTH'(product);
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

/* File: bench/vcf_param_bank_tb.sv */
// Self-checking testbench for the voltage command filter parameter bank.
// Assumes vcf_pkg is compiled first; clock 200 MHz, reset async and active high.
`timescale 1ns/1ps
module vcf_param_bank_tb;
  // Inputs, all driven on the falling edge.
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic boot_phase = 1'b0;
  logic [15:0] command_target = 16'h0000;
  // Outputs of the bank.
  logic [15:0] reg_rdata;
  logic reg_hit;
  logic [15:0] filtered_target;
  logic filter_step;
  logic [15:0] min_output_norm;
  logic [vcf_pkg::COEFF_WIDTH-1:0] boot_filter_coeff;
  logic [vcf_pkg::COEFF_WIDTH-1:0] transition_filter_coeff;
  logic [15:0] boot_duty_norm;
  logic [15:0] transition_slew_recip_value;
  logic [15:0] boot_slew_recip_value;
  // Counters of mismatches, comparisons and elapsed cycles.
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  // The clock toggles every half period of 2.5 ns.
  always #2.5 clk = ~clk;

  vcf_param_bank #(.DATA_WIDTH(16)) u_dut (
    .clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .boot_phase(boot_phase), .command_target(command_target),
    .filtered_target(filtered_target), .filter_step(filter_step),
    .min_output_norm(min_output_norm), .boot_filter_coeff(boot_filter_coeff),
    .transition_filter_coeff(transition_filter_coeff), .boot_duty_norm(boot_duty_norm),
    .transition_slew_recip_value(transition_slew_recip_value),
    .boot_slew_recip_value(boot_slew_recip_value)
  );

  // Prints the verdict once and ends the run.
  task automatic tally_and_finish();
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the expected length of the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end

  // Compares a word-wide result.
  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // Compares a one-bit result.
  task automatic check_flag(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %b, seen %b", name, exp, got);
    end
  endtask

  // One write strobe of one cycle.
  task automatic reg_write(input logic [7:0] addr, input logic [15:0] data);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // One read; the answer stands one cycle and must then return to zero.
  task automatic read_check(input logic [7:0] addr, input logic [15:0] exp, input logic hit);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = addr;
    @(negedge clk);
    reg_rd = 1'b0;
    check_word("reg_rdata", exp, reg_rdata);
    check_flag("reg_hit", hit, reg_hit);
    @(negedge clk);
    check_word("reg_rdata idle", 16'h0000, reg_rdata);
    check_flag("reg_hit idle", 1'b0, reg_hit);
  endtask

  // A write and then a read of the same code in the next cycle return the new word.
  task automatic write_read_back(input logic [7:0] addr, input logic [15:0] data);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check_word("reg_rdata back", data, reg_rdata);
    check_flag("reg_hit back", 1'b1, reg_hit);
  endtask

  // Back-to-back write and read of each full-word register.
  task automatic test_back_to_back();
    write_read_back(vcf_pkg::ADDR_MIN_OUTPUT, 16'h1357);
    write_read_back(vcf_pkg::ADDR_BOOT_DUTY, 16'h2468);
    write_read_back(vcf_pkg::ADDR_TRAN_SLEW, 16'h9abc);
    write_read_back(vcf_pkg::ADDR_BOOT_SLEW, 16'hdef0);
    check_word("min output", 16'h1357, min_output_norm);
    check_word("boot slew", 16'hdef0, boot_slew_recip_value);
  endtask

  // Waits under a bound for the filter step pulse, counting falling edges.
  task automatic wait_step(output int n);
    n = 0;
    while (filter_step !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask

  // All five registers read back zero after reset.
  task automatic test_reset_values();
    for (int a = 8'hb4; a <= 8'hb8; a++) begin
      read_check(8'(a), 16'h0000, 1'b1);
    end
  endtask

  // Each register holds a full word; reserved time-constant bits are dropped.
  task automatic test_write_readback();
    reg_write(vcf_pkg::ADDR_MIN_OUTPUT, 16'h8001);
    reg_write(vcf_pkg::ADDR_BOOT_DUTY, 16'h7ffe);
    reg_write(vcf_pkg::ADDR_TRAN_SLEW, 16'hc35a);
    reg_write(vcf_pkg::ADDR_BOOT_SLEW, 16'h3ca5);
    reg_write(vcf_pkg::ADDR_FILTER_TC, 16'hffff);
    check_word("boot coeff", 16'h003f, {10'h000, boot_filter_coeff});
    check_word("tran coeff", 16'h003f, {10'h000, transition_filter_coeff});
    read_check(vcf_pkg::ADDR_FILTER_TC, 16'h0fff, 1'b1);
    reg_write(vcf_pkg::ADDR_FILTER_TC, 16'ha5a5);
    check_word("boot coeff", 16'h0016, {10'h000, boot_filter_coeff});
    check_word("tran coeff", 16'h0025, {10'h000, transition_filter_coeff});
    read_check(vcf_pkg::ADDR_FILTER_TC, 16'h05a5, 1'b1);
    check_word("min output", 16'h8001, min_output_norm);
    check_word("boot duty", 16'h7ffe, boot_duty_norm);
    check_word("tran slew", 16'hc35a, transition_slew_recip_value);
    check_word("boot slew", 16'h3ca5, boot_slew_recip_value);
    read_check(vcf_pkg::ADDR_MIN_OUTPUT, 16'h8001, 1'b1);
    read_check(vcf_pkg::ADDR_BOOT_DUTY, 16'h7ffe, 1'b1);
    read_check(vcf_pkg::ADDR_TRAN_SLEW, 16'hc35a, 1'b1);
    read_check(vcf_pkg::ADDR_BOOT_SLEW, 16'h3ca5, 1'b1);
  endtask

  // Codes beside the bank are ignored and read as zero without a hit.
  task automatic test_unmapped();
    reg_write(8'hb3, 16'h1234);
    reg_write(8'hb9, 16'h1234);
    read_check(8'hb3, 16'h0000, 1'b0);
    read_check(8'hb9, 16'h0000, 1'b0);
    check_word("min output", 16'h8001, min_output_norm);
    check_word("boot slew", 16'h3ca5, boot_slew_recip_value);
  endtask

  // A read in the cycle of a write returns the value held before it.
  task automatic test_same_cycle();
    @(negedge clk);
    reg_wr = 1'b1;
    reg_rd = 1'b1;
    reg_addr = vcf_pkg::ADDR_MIN_OUTPUT;
    reg_wdata = 16'h0f0f;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    check_word("reg_rdata", 16'h8001, reg_rdata);
    check_word("min output", 16'h0f0f, min_output_norm);
  endtask

  // Boot then transition coefficient drive two filter steps 64 cycles apart.
  task automatic test_filter();
    int n;
    reg_write(vcf_pkg::ADDR_FILTER_TC, 16'h0810);
    command_target = 16'h0800;
    boot_phase = 1'b1;
    wait_step(n);
    check_flag("filter_step", 1'b1, filter_step);
    @(negedge clk);
    check_word("filtered boot", 16'h0020, filtered_target);
    boot_phase = 1'b0;
    wait_step(n);
    check_word("step spacing", 16'(320 / 5 - 1), 16'(n));
    @(negedge clk);
    check_word("filtered tran", 16'h002f, filtered_target);
  endtask

  // Main sequence: hold reset for ten cycles, then run each scenario.
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    test_reset_values();
    test_write_readback();
    test_unmapped();
    test_same_cycle();
    test_back_to_back();
    test_filter();
    tally_and_finish();
  end
endmodule
